// >>> src/acif_consts.vh
`ifndef ACIF_CONSTS_VH
`define ACIF_CONSTS_VH

`define ACIF_NUM_POINTS       32
`define ACIF_LEN_ENABLED      8'h10
`define ACIF_LEN_DISABLED     8'h00
`define ACIF_SET_MIN          7'h01
`define ACIF_SET_MAX          7'h7F
`define ACIF_STEP_MS          20
`define ACIF_CLK_MHZ          200
`define ACIF_CYC_PER_MS       (`ACIF_CLK_MHZ * 1000)
`define ACIF_CYC_PER_STEP     (`ACIF_STEP_MS * `ACIF_CYC_PER_MS)
`define ACIF_OFF_INPUT        12'h000
`define ACIF_OFF_CTRL         12'h004
`define ACIF_OFF_STATUS       12'h008
`define ACIF_OFF_EVENT        12'h00C
`define ACIF_OFF_MASK         12'h010
`define ACIF_CTRL_FLTLEN_LO   0
`define ACIF_CTRL_FLTSET_LO   8
`define ACIF_CTRL_STSLEN_LO   16
`define ACIF_STS_NOTREADY     9
`define ACIF_STS_TBLOCK       0
`define ACIF_STS_FLTON        1
`define ACIF_STS_SETBAD       2
`define ACIF_EV_ADD           0
`define ACIF_EV_LOSS          1
`define ACIF_RST_CTRL         32'h0000_0000

`endif

// >>> src/acif_filter_status.v
// Summary of operation
// - thirty-two filtered input bits are readable by the controller.
// - one indicator per point follows its filtered on/off state.
// - one filter time is shared by all thirty-two inputs.
// - length 16 enables filtering; length zero bypasses the filter entirely.
// - filter time equals setting times 20 ms, up to 2540 ms.
// - response jitter bounded by AC cycles depending on filter time.
// - status defaults to length zero; delivered only when length is 16.
// - internal status uses only the lowest ten of sixteen bits.
// - status bit 9 is one when not ready, zero when ready.
// - terminal block indicator green when locked, red when not.
// - each lock change raises an addition or loss event to the controller.
`timescale 1ns/1ps
`default_nettype none
`include "acif_consts.vh"

module acif_filter_status #(
  parameter integer NPTS        = `ACIF_NUM_POINTS,
  parameter integer CYC_PER_STEP = `ACIF_CYC_PER_STEP
) (
  input  wire              clk_sys,
  input  wire              rst,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire [NPTS-1:0]   fieldIn,
  input  wire              tblockLocked,
  input  wire              moduleReady,
  output reg  [NPTS-1:0]   pointLed,
  output reg               terminal_block_lock_indicator_green,
  output reg               terminal_block_lock_indicator_red,
  output reg               irq
);

  localparam integer TW = 32;

  // pin synchronisers: first stage read only by the second
  reg [NPTS-1:0] inMeta_q;
  reg [NPTS-1:0] inSync_q;
  reg            tbMeta_q;
  reg            tbSync_q;
  reg            rdyMeta_q;
  reg            rdySync_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      inMeta_q  <= {NPTS{1'b0}};
      inSync_q  <= {NPTS{1'b0}};
      tbMeta_q  <= 1'b0;
      tbSync_q  <= 1'b0;
      rdyMeta_q <= 1'b0;
      rdySync_q <= 1'b0;
    end else begin
      inMeta_q  <= fieldIn;
      inSync_q  <= inMeta_q;
      tbMeta_q  <= tblockLocked;
      tbSync_q  <= tbMeta_q;
      rdyMeta_q <= moduleReady;
      rdySync_q <= rdyMeta_q;
    end
  end

  // control register: filter length, setting, status length
  reg  [31:0] ctrl_q;
  reg  [1:0]  event_q;
  reg  [1:0]  mask_q;
  wire [7:0]  fltLen  = ctrl_q[`ACIF_CTRL_FLTLEN_LO +: 8];
  wire [6:0]  fltSet  = ctrl_q[`ACIF_CTRL_FLTSET_LO +: 7];
  wire [7:0]  stsLen  = ctrl_q[`ACIF_CTRL_STSLEN_LO +: 8];
  wire        fltOn   = (fltLen == `ACIF_LEN_ENABLED);
  wire        setBad  = (fltSet < `ACIF_SET_MIN);
  // setting 0 is refused; treated as the shortest valid step
  wire [6:0]  setUse  = setBad ? `ACIF_SET_MIN : fltSet;
  // target in clock cycles; setting times one 20 ms step
  wire [TW-1:0] stepCyc = CYC_PER_STEP;
  wire [TW-1:0] target  = setUse * stepCyc;

  // separate time bases: one counter per point, shared target
  // each point owns its own flop so every bit has a single driver
  wire [NPTS-1:0] filt_q;
  genvar g;
  generate
    for (g = 0; g < NPTS; g = g + 1) begin : gPt
      reg [TW-1:0] cnt_q;
      reg          bit_q;
      assign filt_q[g] = bit_q;
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          cnt_q      <= {TW{1'b0}};
          bit_q      <= 1'b0;
        end else if (!fltOn || inSync_q[g] == bit_q) begin
          // bypass when disabled; any bounce restarts the hold
          cnt_q      <= {TW{1'b0}};
          bit_q      <= inSync_q[g];
        end else if (cnt_q + 1'b1 >= target) begin
          // new level held for the whole filter time
          cnt_q      <= {TW{1'b0}};
          bit_q      <= inSync_q[g];
        end else begin
          cnt_q      <= cnt_q + 1'b1;
        end
      end
    end
  endgenerate

  // jitter is a field-side figure; sampling here adds only two clock cycles

  // indicators
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pointLed <= {NPTS{1'b0}};
      terminal_block_lock_indicator_green <= 1'b0;
      terminal_block_lock_indicator_red   <= 1'b1;
    end else begin
      pointLed <= filt_q;
      terminal_block_lock_indicator_green <= tbSync_q;
      terminal_block_lock_indicator_red   <= ~tbSync_q;
    end
  end

  // lock change detect
  reg  tbPrev_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tbPrev_q <= 1'b0;
    end else begin
      tbPrev_q <= tbSync_q;
    end
  end
  wire evAdd  = tbSync_q & ~tbPrev_q;
  wire evLoss = ~tbSync_q & tbPrev_q;

  // status word: ten low bits used, bit 9 inverted sense
  wire [15:0] stsWord;
  assign stsWord[`ACIF_STS_TBLOCK]   = tbSync_q;
  assign stsWord[`ACIF_STS_FLTON]    = fltOn;
  assign stsWord[`ACIF_STS_SETBAD]   = fltOn & setBad;
  assign stsWord[8:3]                = 6'h00;
  assign stsWord[`ACIF_STS_NOTREADY] = ~rdySync_q;
  assign stsWord[15:10]              = 6'h00;
  wire        stsOn  = (stsLen == `ACIF_LEN_ENABLED);
  wire [15:0] stsOut = stsOn ? stsWord : 16'h0000;

  // apb slave, zero wait states
  wire wrEn = psel & penable & pwrite;
  wire rdEn = psel & ~penable & ~pwrite;
  wire hit  = (paddr == `ACIF_OFF_INPUT) || (paddr == `ACIF_OFF_CTRL) ||
              (paddr == `ACIF_OFF_STATUS) || (paddr == `ACIF_OFF_EVENT) ||
              (paddr == `ACIF_OFF_MASK);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= `ACIF_RST_CTRL;
      mask_q <= 2'h0;
    end else if (wrEn && paddr == `ACIF_OFF_CTRL) begin
      // new setting applies on the very next count compare
      ctrl_q <= pwdata;
    end else if (wrEn && paddr == `ACIF_OFF_MASK) begin
      mask_q <= pwdata[1:0];
    end
  end

  // sticky events: set wins over write-one-to-clear
  wire [1:0] evSet = {evLoss, evAdd};
  wire [1:0] evClr = (wrEn && paddr == `ACIF_OFF_EVENT) ? pwdata[1:0] : 2'h0;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      event_q <= 2'h0;
      irq     <= 1'b0;
    end else begin
      event_q <= (event_q & ~evClr) | evSet;
      irq     <= |(((event_q & ~evClr) | evSet) & mask_q);
    end
  end

  // read data registered in the setup cycle, valid in the access cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      case (paddr)
        `ACIF_OFF_INPUT:  prdata <= filt_q;
        `ACIF_OFF_CTRL:   prdata <= ctrl_q;
        `ACIF_OFF_STATUS: prdata <= {16'h0000, stsOut};
        `ACIF_OFF_EVENT:  prdata <= {30'h0000_0000, event_q};
        `ACIF_OFF_MASK:   prdata <= {30'h0000_0000, mask_q};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> tb/acif_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module acif_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  logic hung = 1'b0;
  initial {psel, penable, pwrite, paddr, pwdata} = 47'h0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [32:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (!pready && ++n < 64);
    hung = !pready;
    q = {pslverr, prdata};
    {psel, penable} <= 2'h0;
  endtask
  // one control write carries setting, filter length and status length 16
  task automatic setFilter(input logic [6:0] s, input logic [7:0] len);
    logic [32:0] q;
    xfer(1'b1, 12'h004, {16'h0010, 1'b0, s, len}, q);
  endtask
endmodule
`default_nettype wire

// >>> tb/acif_filter_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h", $time, a); end end
module acif_filter_status_bench;
  logic        clk_sys = 1'b0, rst = 1'b1, tblockLocked = 1'b0, moduleReady = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic        terminal_block_lock_indicator_green, terminal_block_lock_indicator_red;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pointLed, fieldIn = 32'h0;
  logic [32:0] q;
  int          errors = 0, checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  acif_filter_status #(.CYC_PER_STEP(10)) DUT (.*);
  acif_cpu_model cpu (.*);
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    cpu.xfer(1'b0, a, 32'h0, q);
    if (cpu.hung) begin
      errors++;
      end_of_test();
    end else begin
      `CHK(q, e)
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, q);
    if (cpu.hung) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  initial begin
    waitc(4);
    rst <= 1'b0;
    rd(12'h004, 33'h0);
    rd(12'h008, 33'h0);
    rd(12'h020, 33'h1_0000_0000);
    cpu.setFilter(7'h02, 8'h10);
    rd(12'h004, 33'h0_0010_0210);
    rd(12'h008, 33'h202);
    $display("register test done");
    tblockLocked <= 1'b1;
    moduleReady <= 1'b1;
    waitc(6);
    rd(12'h008, 33'h003);
    `CHK(irq, 1'b0)
    wr(12'h010, 32'h3);
    tblockLocked <= 1'b0;
    waitc(6);
    `CHK(irq, 1'b1)
    rd(12'h00C, 33'h3);
    `CHK(terminal_block_lock_indicator_red, 1'b1)
    wr(12'h00C, 32'h3);
    waitc(2);
    `CHK(irq, 1'b0)
    $display("lock test done");
    fieldIn <= 32'hA5A5_0F0F;
    waitc(10);
    rd(12'h000, 33'h0);
    waitc(20);
    rd(12'h000, 33'h0_A5A5_0F0F);
    fieldIn <= 32'h0;
    waitc(12);
    fieldIn <= 32'hA5A5_0F0F;
    waitc(30);
    rd(12'h000, 33'h0_A5A5_0F0F);
    cpu.setFilter(7'h01, 8'h10);
    fieldIn <= 32'h0;
    waitc(14);
    rd(12'h000, 33'h0);
    cpu.setFilter(7'h01, 8'h00);
    fieldIn <= 32'h1234_5678;
    waitc(3);
    rd(12'h000, 33'h0_1234_5678);
    `CHK(pointLed, 32'h1234_5678)
    $display("filter test done");
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> tb/acif_filter_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acif_filter_status_sva #(
  parameter integer NPTS         = 32,
  parameter integer CYC_PER_STEP = 10
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tblockLocked,
  input wire logic        terminal_block_lock_indicator_green,
  input wire logic        terminal_block_lock_indicator_red
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire grn = terminal_block_lock_indicator_green;
  wire red = terminal_block_lock_indicator_red;
  // lock input passes two sync flops, so allow five cycles
  chk_led_pair: assert property (red != grn) else $error("led pair");
  chk_lock_grn: assert property (tblockLocked [*5] |-> grn) else $error("green");
  chk_free_red: assert property (!tblockLocked [*5] |-> red) else $error("red");
  chk_bus_ready: assert property (pready) else $error("pready");
  chk_err_phase: assert property (pslverr |-> acc) else $error("pslverr");
  chk_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("rdata");
  chk_err_map: assert property (acc |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008,
    12'h00C, 12'h010})) else $error("map");
  chk_sts_width: assert property (acc && !pwrite && paddr == 12'h008 |-> prdata[31:10] == 22'h0)
    else $error("status");
  cover property (pslverr);
  cover property ($fell(grn));
  cover property (acc && paddr == 12'h008);
endmodule
bind acif_filter_status acif_filter_status_sva #(.NPTS(NPTS), .CYC_PER_STEP(CYC_PER_STEP)) chk (.*);
`default_nettype wire
